//--- design/frpc_top.sv
// Purpose: Control side of one fabric slice: cells, emulated bus, globals, pins.
// Assumes: APB3 slave, inputs synchronous to pclk.
// Notes: Every top output is a flip-flop; pin outputs lag routing by one cycle.
`timescale 1ns/1ps
`include "frpc_map.svh"

module frpc_top #(
    parameter int CELLS = `FRPC_CELLS,
    parameter int PINS = `FRPC_PINS,
    parameter int GLOBALS = `FRPC_GLOBALS,
    parameter int DRIVERS = `FRPC_BUS_DRIVERS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire frpc_pkg::frpc_addr_type paddr,
    input wire frpc_pkg::frpc_word_type pwdata,
    output frpc_pkg::frpc_word_type prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lab_control_one_n,
    input wire logic lab_control_two_n,
    input wire logic cnt_en,
    input wire logic sync_clr,
    input wire logic sync_ld,
    input wire logic carry_in,
    input wire logic [CELLS-1:0] cell_d,
    input wire logic [CELLS-1:0] cell_ld_data,
    input wire logic [CELLS-1:0] cell_cascade_in,
    output logic [CELLS-1:0] cell_q,
    input wire logic [DRIVERS-1:0] bus_drv_data,
    input wire logic [DRIVERS-1:0] bus_drv_en,
    output logic bus_level,
    input wire logic [GLOBALS-1:0] ded_in,
    input wire logic [GLOBALS-1:0] cell_global_val,
    output logic [GLOBALS-1:0] global_ctrl,
    output logic [GLOBALS-1:0] ded_data,
    input wire logic [PINS-1:0] route_data,
    input wire logic [PINS-1:0] route_oe,
    input wire logic chip_output_disable,
    input wire logic [PINS-1:0] pad_i,
    output logic [PINS-1:0] pad_o,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pin_in_data
);
    import frpc_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        frpc_apb_state_type apb_state;
        frpc_word_type prdata;
        logic pready;
        logic pslverr;
        logic counter_mode;
        logic fast_fb;
        logic [CELLS-1:0] clr_sel;
        logic [CELLS-1:0] clr_use;
        logic [CELLS-1:0] preset;
        logic [PINS-1:0] inv_data;
        logic [PINS-1:0] inv_oe;
        logic [PINS-1:0] open_drain;
        logic [GLOBALS-1:0] global_sel;
        logic [CELLS-1:0] cell_q;
        logic bus_level;
        logic [GLOBALS-1:0] global_ctrl;
        logic [GLOBALS-1:0] ded_data;
        logic [PINS-1:0] pad_o;
        logic [PINS-1:0] pad_oe;
        logic [PINS-1:0] pin_in;
    } frpc_top_state_type;

    frpc_top_state_type state_reg;
    frpc_top_state_type state_next;

    logic [CELLS-1:0] q_w;
    logic [CELLS:0] carry_w;
    logic bus_w;
    logic [GLOBALS-1:0] global_w;
    logic [PINS-1:0] data_w;
    logic [PINS-1:0] oe_w;

    // ==========================================================
    // Address decode, shared by read and write
    function automatic logic [3:0] reg_index(input frpc_addr_type a);
        logic [3:0] idx;
        idx = `FRPC_NO_REG;
        if (a == `FRPC_ADDR_CTRL) begin
            idx = 4'h0;
        end else if (a == `FRPC_ADDR_CLR_SEL) begin
            idx = 4'h1;
        end else if (a == `FRPC_ADDR_CLR_USE) begin
            idx = 4'h2;
        end else if (a == `FRPC_ADDR_PRESET) begin
            idx = 4'h3;
        end else if (a == `FRPC_ADDR_INV_DATA) begin
            idx = 4'h4;
        end else if (a == `FRPC_ADDR_INV_OE) begin
            idx = 4'h5;
        end else if (a == `FRPC_ADDR_OPEN_DRAIN) begin
            idx = 4'h6;
        end else if (a == `FRPC_ADDR_GLOBAL_SEL) begin
            idx = 4'h7;
        end else if (a == `FRPC_ADDR_CELL_STAT) begin
            idx = 4'h8;
        end else if (a == `FRPC_ADDR_LINE_STAT) begin
            idx = 4'h9;
        end
        return idx;
    endfunction

    // ==========================================================
    // Cell group
    assign carry_w[0] = carry_in;

    for (genvar i = 0; i < CELLS; i++) begin : g_cell
        frpc_cell u_cell (
            .pclk(pclk),
            .presetn(presetn),
            .lab_control_one_n(lab_control_one_n),
            .lab_control_two_n(lab_control_two_n),
            .clr_use(state_reg.clr_use[i]),
            .clr_sel(state_reg.clr_sel[i]),
            .preset_mode(state_reg.preset[i]),
            .counter_mode(state_reg.counter_mode),
            .fast_fb(state_reg.fast_fb && (i == `FRPC_FAST_FB_CELL)),
            .cnt_en(cnt_en),
            .sync_clr(sync_clr),
            .sync_ld(sync_ld),
            .ld_data(cell_ld_data[i]),
            .lut_d(cell_d[i]),
            .cascade_in(cell_cascade_in[i]),
            .carry_in(carry_w[i]),
            .q(q_w[i]),
            .carry_out(carry_w[i+1])
        );
    end

    // ==========================================================
    // Emulated internal bus
    frpc_tri_bus #(
        .DRIVERS(DRIVERS)
    ) u_bus (
        .drv_data(bus_drv_data),
        .drv_en(bus_drv_en),
        .level(bus_w)
    );

    // ==========================================================
    // Global lines and pin cells
    always_comb begin
        // A cell driving a line takes it away from its dedicated input
        global_w = (state_reg.global_sel & cell_global_val) | (~state_reg.global_sel & ded_in);
        data_w = route_data ^ state_reg.inv_data;
        oe_w = route_oe ^ state_reg.inv_oe;
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.cell_q = q_w;
        state_next.bus_level = bus_w;
        state_next.global_ctrl = global_w;
        state_next.ded_data = ded_in;
        state_next.pin_in = pad_i;
        for (int p = 0; p < PINS; p++) begin
            // Open drain only ever drives low; the enable does the toggling
            state_next.pad_o[p] = state_reg.open_drain[p] ? 1'b0 : data_w[p];
            state_next.pad_oe[p] = oe_w[p] & ~chip_output_disable;
        end

        case (state_reg.apb_state)
            FRPC_IDLE: begin
                state_next.pready = 1'b0;
                state_next.pslverr = 1'b0;
                if (psel && penable) begin
                    state_next.apb_state = FRPC_RESP;
                    state_next.pready = 1'b1;
                    state_next.prdata = `FRPC_RST_WORD;
                    if (reg_index(paddr) == `FRPC_NO_REG) begin
                        state_next.pslverr = 1'b1;
                    end else if (!pwrite) begin
                        case (reg_index(paddr))
                            4'h0: begin
                                state_next.prdata[`FRPC_CTRL_CNT_BIT] = state_reg.counter_mode;
                                state_next.prdata[`FRPC_CTRL_FB_BIT] = state_reg.fast_fb;
                            end
                            4'h1: state_next.prdata = 32'(state_reg.clr_sel);
                            4'h2: state_next.prdata = 32'(state_reg.clr_use);
                            4'h3: state_next.prdata = 32'(state_reg.preset);
                            4'h4: state_next.prdata = 32'(state_reg.inv_data);
                            4'h5: state_next.prdata = 32'(state_reg.inv_oe);
                            4'h6: state_next.prdata = 32'(state_reg.open_drain);
                            4'h7: state_next.prdata = 32'(state_reg.global_sel);
                            4'h8: state_next.prdata = 32'(state_reg.cell_q);
                            default: begin
                                state_next.prdata[`FRPC_STAT_BUS_BIT] = state_reg.bus_level;
                                state_next.prdata[`FRPC_STAT_GLB_LSB +: GLOBALS] =
                                    state_reg.global_ctrl;
                                state_next.prdata[`FRPC_STAT_DED_LSB +: GLOBALS] =
                                    state_reg.ded_data;
                                state_next.prdata[`FRPC_STAT_PIN_LSB +: PINS] = state_reg.pin_in;
                            end
                        endcase
                    end
                end
            end
            FRPC_RESP: begin
                // Writes land on the edge that samples pready high
                state_next.apb_state = FRPC_IDLE;
                state_next.pready = 1'b0;
                state_next.pslverr = 1'b0;
                if (psel && penable && pwrite) begin
                    case (reg_index(paddr))
                        4'h0: begin
                            state_next.counter_mode = pwdata[`FRPC_CTRL_CNT_BIT];
                            state_next.fast_fb = pwdata[`FRPC_CTRL_FB_BIT];
                        end
                        4'h1: state_next.clr_sel = pwdata[CELLS-1:0];
                        4'h2: state_next.clr_use = pwdata[CELLS-1:0];
                        4'h3: state_next.preset = pwdata[CELLS-1:0];
                        4'h4: state_next.inv_data = pwdata[PINS-1:0];
                        4'h5: state_next.inv_oe = pwdata[PINS-1:0];
                        4'h6: state_next.open_drain = pwdata[PINS-1:0];
                        4'h7: state_next.global_sel = pwdata[GLOBALS-1:0];
                        default: begin
                            // Status words and holes ignore writes
                            state_next.prdata = state_reg.prdata;
                        end
                    endcase
                end
            end
            default: begin
                state_next.apb_state = FRPC_IDLE;
                state_next.pready = 1'b0;
                state_next.pslverr = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.apb_state <= FRPC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign cell_q = state_reg.cell_q;
    assign bus_level = state_reg.bus_level;
    assign global_ctrl = state_reg.global_ctrl;
    assign ded_data = state_reg.ded_data;
    assign pad_o = state_reg.pad_o;
    assign pad_oe = state_reg.pad_oe;
    assign pin_in_data = state_reg.pin_in;
endmodule

//--- design/frpc_map.svh
// Purpose: Register offsets, field positions and reset values of the fabric control block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Definitions only.
`ifndef FRPC_MAP_SVH
`define FRPC_MAP_SVH

// ==========================================================
// Register offsets
`define FRPC_ADDR_CTRL 12'h000
`define FRPC_ADDR_CLR_SEL 12'h004
`define FRPC_ADDR_CLR_USE 12'h008
`define FRPC_ADDR_PRESET 12'h00C
`define FRPC_ADDR_INV_DATA 12'h010
`define FRPC_ADDR_INV_OE 12'h014
`define FRPC_ADDR_OPEN_DRAIN 12'h018
`define FRPC_ADDR_GLOBAL_SEL 12'h01C
`define FRPC_ADDR_CELL_STAT 12'h020
`define FRPC_ADDR_LINE_STAT 12'h024

// ==========================================================
// Field positions
`define FRPC_CTRL_CNT_BIT 0
`define FRPC_CTRL_FB_BIT 1
`define FRPC_STAT_BUS_BIT 0
`define FRPC_STAT_GLB_LSB 4
`define FRPC_STAT_DED_LSB 8
`define FRPC_STAT_PIN_LSB 16

// ==========================================================
// Reset values and sizes
`define FRPC_RST_WORD 32'h0000_0000
`define FRPC_NO_REG 4'hF
`define FRPC_FAST_FB_CELL 1
`define FRPC_GLOBALS 4
`define FRPC_CELLS 10
`define FRPC_PINS 8
`define FRPC_BUS_DRIVERS 4

`endif

//--- design/frpc_pkg.sv
// Purpose: Shared types of the fabric control block.
// Assumes: Nothing beyond the map header.
// Notes: State structs depend on parameters and live in the modules.
package frpc_pkg;

    // ==========================================================
    // APB slave phase, one-hot
    typedef enum logic [1:0] {
        FRPC_IDLE = 2'b01,
        FRPC_RESP = 2'b10
    } frpc_apb_state_type;

    typedef logic [11:0] frpc_addr_type;
    typedef logic [31:0] frpc_word_type;

endpackage

//--- design/frpc_tri_bus.sv
// Purpose: Emulated internal tri-state bus built as a multiplexer.
// Assumes: One enable and one data bit per driver.
// Notes: Purely combinational; the caller registers the level.
`timescale 1ns/1ps
`include "frpc_map.svh"
module frpc_tri_bus #(
    parameter int DRIVERS = `FRPC_BUS_DRIVERS
) (
    input wire logic [DRIVERS-1:0] drv_data,
    input wire logic [DRIVERS-1:0] drv_en,
    output logic level
);
    import frpc_pkg::*;

    logic [DRIVERS-1:0] en_less_one;
    logic multi;

    always_comb begin
        en_less_one = drv_en - DRIVERS'(1);
        multi = |(drv_en & en_less_one);
        if (drv_en == '0) begin
            // Never floats
            level = 1'b1;
        end else if (multi) begin
            // Contention resolves low
            level = 1'b0;
        end else begin
            level = |(drv_data & drv_en);
        end
    end
endmodule

//--- design/frpc_cell.sv
// Purpose: One logic cell register with clear or preset and counter mode.
// Assumes: Clear sources are active-low group control lines.
// Notes: Preset is stored inverted so one constant clear serves both modes.
`timescale 1ns/1ps
module frpc_cell (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic lab_control_one_n,
    input wire logic lab_control_two_n,
    input wire logic clr_use,
    input wire logic clr_sel,
    input wire logic preset_mode,
    input wire logic counter_mode,
    input wire logic fast_fb,
    input wire logic cnt_en,
    input wire logic sync_clr,
    input wire logic sync_ld,
    input wire logic ld_data,
    input wire logic lut_d,
    input wire logic cascade_in,
    input wire logic carry_in,
    output logic q,
    output logic carry_out
);
    import frpc_pkg::*;

    typedef struct packed {
        logic stored;
    } frpc_cell_state_type;

    frpc_cell_state_type state_reg;
    frpc_cell_state_type state_next;
    logic clr_n;
    logic cin;
    logic value_next;

    // ==========================================================
    // Clear source
    // An unused clear is held high so it never acts
    assign clr_n = presetn & (~clr_use | (clr_sel ? lab_control_two_n : lab_control_one_n));

    // ==========================================================
    // Next value
    always_comb begin
        q = state_reg.stored ^ preset_mode;
        // Fast feedback lets a chain start here from cnt_en instead of the incoming carry
        cin = fast_fb ? cnt_en : carry_in;
        carry_out = q & cin;
        if (counter_mode) begin
            if (sync_clr) begin
                value_next = 1'b0;
            end else if (sync_ld) begin
                value_next = ld_data;
            end else begin
                value_next = (q ^ cin) & cascade_in;
            end
        end else begin
            value_next = lut_d & cascade_in;
        end
        state_next.stored = value_next ^ preset_mode;
    end

    // Cleared store reads back as one in preset mode
    always_ff @(posedge pclk or negedge clr_n) begin
        if (!clr_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

//--- verification/frpc_board.sv
// Purpose: Board side of the pins: pads with pull-ups.
// Assumes: One pad per pin cell.
// Notes: A released pad reads high, so open-drain pins show a wired level.
`timescale 1ns/1ps
module frpc_board #(
    parameter int PINS = 8
) (
    input wire logic [PINS-1:0] pad_o,
    input wire logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pad_i
);
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            pad_i[i] = pad_oe[i] ? pad_o[i] : 1'b1;
        end
    end
endmodule

//--- verification/frpc_asserts.sv
// Purpose: Port-level checks of the fabric control block.
// Assumes: Bound to the top module.
// Notes: Relations that depend on register contents are left to the bench.
`timescale 1ns/1ps
module frpc_asserts #(
    parameter int PINS = 8,
    parameter int GLOBALS = 4,
    parameter int DRIVERS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [DRIVERS-1:0] bus_drv_data,
    input wire logic [DRIVERS-1:0] bus_drv_en,
    input wire logic bus_level,
    input wire logic [GLOBALS-1:0] ded_in,
    input wire logic [GLOBALS-1:0] cell_global_val,
    input wire logic [GLOBALS-1:0] global_ctrl,
    input wire logic [GLOBALS-1:0] ded_data,
    input wire logic chip_output_disable,
    input wire logic [PINS-1:0] pad_i,
    input wire logic [PINS-1:0] pad_oe,
    input wire logic [PINS-1:0] pin_in_data
);
    // Outputs still hold reset values on the release edge, so checks start one edge later
    logic live_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_reg <= 1'b0;
        end else begin
            live_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !live_reg);
    // ==========================================================
    // Emulated bus
    property p_bus_clash;
        $countones(bus_drv_en) > 1 |=> bus_level == 1'b0;
    endproperty
    a_bus_clash: assert property (p_bus_clash) else $error("bus not low on clash");
    property p_bus_float;
        bus_drv_en == '0 |=> bus_level == 1'b1;
    endproperty
    a_bus_float: assert property (p_bus_float) else $error("bus not high when idle");
    property p_bus_one;
        $onehot(bus_drv_en) |=> bus_level == $past(|(bus_drv_data & bus_drv_en));
    endproperty
    a_bus_one: assert property (p_bus_one) else $error("bus lost single driver");
    // ==========================================================
    // Pins and global lines
    property p_oe_off;
        chip_output_disable |=> pad_oe == '0;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pins drive while disabled");
    property p_oe_hold;
        chip_output_disable [*3] |-> pad_oe == '0 && $stable(pad_oe);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin enable beat disable");
    property p_pin_in;
        1'b1 |=> pin_in_data == $past(pad_i);
    endproperty
    a_pin_in: assert property (p_pin_in) else $error("pad input not captured");
    property p_ded;
        1'b1 |=> ded_data == $past(ded_in);
    endproperty
    a_ded: assert property (p_ded) else $error("dedicated data lost");
    property p_glb;
        ded_in == cell_global_val |=> global_ctrl == $past(ded_in);
    endproperty
    a_glb: assert property (p_glb) else $error("global line wrong source");
    // ==========================================================
    // Register bus timing
    property p_rdy;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready not a one-cycle answer");
    c_clash: cover property ($countones(bus_drv_en) > 1);
    c_off: cover property (chip_output_disable [*3]);
    c_rdy: cover property (pready);
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench of the fabric control block.
// Assumes: One pclk domain; APB answer waited for, never counted.
// Notes: Pads sit on a pull-up board model.
`timescale 1ns/1ps
`include "frpc_map.svh"
module tb;
    import frpc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_level;
    logic lab_control_one_n, lab_control_two_n, cnt_en, sync_clr, sync_ld, carry_in;
    logic chip_output_disable;
    frpc_addr_type paddr;
    frpc_word_type pwdata, prdata;
    logic [9:0] cell_d, cell_ld_data, cell_cascade_in, cell_q;
    logic [3:0] bus_drv_data, bus_drv_en, ded_in, cell_global_val, global_ctrl, ded_data;
    logic [7:0] route_data, route_oe, pad_i, pad_o, pad_oe, pin_in_data;
    int n_mismatch = 0;
    int checked = 0;
    localparam logic [31:0] MASK [8] = '{32'h0000_0003, 32'h0000_03FF, 32'h0000_03FF,
        32'h0000_03FF, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_000F};
    frpc_top DUT (.*);
    frpc_board u_board (.pad_o(pad_o), .pad_oe(pad_oe), .pad_i(pad_i));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic summarize;
        $display("Counts: checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Release then idle one cycle, so no signal is driven twice in a time step
    task automatic apb(input logic wr, input frpc_addr_type a, input frpc_word_type d,
                       output frpc_word_type rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input frpc_addr_type a, input frpc_word_type d);
        frpc_word_type rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rchk(input frpc_addr_type a, input frpc_word_type exp, input string what);
        frpc_word_type rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(what, exp, rd);
    endtask
    task automatic bus_case(input logic [3:0] en, input logic [3:0] d, input logic exp);
        bus_drv_en <= en;
        bus_drv_data <= d;
        cyc(2);
        chk("bus_level", 32'(exp), 32'(bus_level));
    endtask
    initial begin
        frpc_word_type rd;
        logic err;
        {psel, penable, pwrite, cnt_en, sync_clr, sync_ld, carry_in} = '0;
        {chip_output_disable, lab_control_one_n, lab_control_two_n} = 3'b011;
        {paddr, pwdata, cell_d, cell_ld_data, bus_drv_data, bus_drv_en} = '0;
        {ded_in, cell_global_val, route_data, route_oe} = '0;
        cell_cascade_in = '1;
        presetn = 1'b0;
        cyc(3);
        presetn <= 1'b1;
        @(posedge pclk);
        // ==========================================================
        // Registers
        for (int i = 0; i < 8; i++) begin
            rchk(12'(4 * i), 32'h0000_0000, "reset value");
            wr(12'(4 * i), 32'hFFFF_FFFF);
            rchk(12'(4 * i), MASK[i], "write mask");
            wr(12'(4 * i), 32'h0000_0000);
        end
        apb(1'b0, 12'h030, 32'h0, rd, err);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        $display("done: registers");
        // ==========================================================
        // Emulated bus
        bus_case(4'h0, 4'h0, 1'b1);
        bus_case(4'h3, 4'h3, 1'b0);
        bus_case(4'h4, 4'h4, 1'b1);
        bus_case(4'h8, 4'h7, 1'b0);
        $display("done: bus");
        // ==========================================================
        // Pins
        route_oe <= 8'hFF;
        route_data <= 8'hA5;
        cyc(2);
        chk("pad_o", 32'h0000_00A5, 32'(pad_o));
        wr(`FRPC_ADDR_INV_DATA, 32'h0000_000F);
        wr(`FRPC_ADDR_INV_OE, 32'h0000_00F0);
        cyc(2);
        chk("pad_o inv", 32'h0000_00AA, 32'(pad_o));
        chk("pad_oe inv", 32'h0000_000F, 32'(pad_oe));
        rchk(`FRPC_ADDR_LINE_STAT, 32'h00FA_0000, "line status");
        wr(`FRPC_ADDR_OPEN_DRAIN, 32'h0000_00FF);
        cyc(2);
        chk("pad_o drain", 32'h0000_0000, 32'(pad_o));
        chk("pin_in drain", 32'h0000_00F0, 32'(pin_in_data));
        route_oe <= 8'h0F;
        cyc(3);
        chk("pin_in toggled", 32'h0000_0000, 32'(pin_in_data));
        chip_output_disable <= 1'b1;
        cyc(3);
        chk("pad_oe disabled", 32'h0000_0000, 32'(pad_oe));
        chk("pin_in disabled", 32'h0000_00FF, 32'(pin_in_data));
        chip_output_disable <= 1'b0;
        $display("done: pins");
        // ==========================================================
        // Global lines
        wr(`FRPC_ADDR_GLOBAL_SEL, 32'h0000_0005);
        ded_in <= 4'h3;
        cell_global_val <= 4'hC;
        cyc(2);
        chk("global_ctrl", 32'h0000_0006, 32'(global_ctrl));
        chk("ded_data", 32'h0000_0003, 32'(ded_data));
        $display("done: globals");
        // ==========================================================
        // Clear and preset
        cell_d <= 10'h01F;
        wr(`FRPC_ADDR_CLR_USE, 32'h0000_03FF);
        wr(`FRPC_ADDR_PRESET, 32'h0000_03E0);
        chk("cell load", 32'h0000_001F, 32'(cell_q));
        lab_control_one_n <= 1'b0;
        cyc(2);
        chk("clear one", 32'h0000_03E0, 32'(cell_q));
        lab_control_one_n <= 1'b1;
        wr(`FRPC_ADDR_CLR_SEL, 32'h0000_03FF);
        lab_control_one_n <= 1'b0;
        cyc(2);
        chk("line one unused", 32'h0000_001F, 32'(cell_q));
        lab_control_one_n <= 1'b1;
        lab_control_two_n <= 1'b0;
        cyc(2);
        chk("clear two", 32'h0000_03E0, 32'(cell_q));
        wr(`FRPC_ADDR_CLR_USE, 32'h0000_0000);
        cyc(2);
        chk("clear unused", 32'h0000_001F, 32'(cell_q));
        lab_control_two_n <= 1'b1;
        wr(`FRPC_ADDR_PRESET, 32'h0000_0000);
        $display("done: clear");
        // ==========================================================
        // Counter mode
        wr(`FRPC_ADDR_CTRL, 32'h0000_0001);
        sync_clr <= 1'b1;
        cyc(3);
        chk("sync clear", 32'h0000_0000, 32'(cell_q));
        {sync_clr, cnt_en, carry_in} <= 3'b011;
        cyc(5);
        {cnt_en, carry_in} <= 2'b00;
        cyc(2);
        chk("count", 32'h0000_0005, 32'(cell_q));
        cell_ld_data <= 10'h2AA;
        cell_cascade_in <= '0;
        {sync_ld, sync_clr} <= 2'b11;
        cyc(3);
        chk("clear over load", 32'h0000_0000, 32'(cell_q));
        sync_clr <= 1'b0;
        cyc(3);
        chk("load over cascade", 32'h0000_02AA, 32'(cell_q));
        sync_ld <= 1'b0;
        cell_cascade_in <= '1;
        wr(`FRPC_ADDR_CTRL, 32'h0000_0003);
        sync_clr <= 1'b1;
        cyc(1);
        {sync_clr, cnt_en} <= 2'b01;
        cyc(4);
        cnt_en <= 1'b0;
        cyc(2);
        chk("fast feedback", 32'h0000_0008, 32'(cell_q));
        rchk(`FRPC_ADDR_CELL_STAT, 32'h0000_0008, "cell status");
        $display("done: counter");
        summarize();
    end
endmodule
bind frpc_top frpc_asserts #(.PINS(PINS), .GLOBALS(GLOBALS), .DRIVERS(DRIVERS)) u_chk (.*);
